// ---- src/rtimer_pkg.sv ----
// package: register map, field positions and timing constants of the timer unit
package rtimer_pkg;
  // register word indices (word aligned on the bus: byte address = 4 * index)
  localparam logic [7:0] IDX_T3_RELOAD_HIGH  = 8'h1f;
  localparam logic [7:0] IDX_T3_RELOAD_LOW   = 8'h20;
  localparam logic [7:0] IDX_T3_COUNT_HIGH   = 8'h21;
  localparam logic [7:0] IDX_T3_COUNT_LOW    = 8'h22;
  localparam logic [7:0] IDX_WAKEUP_CONTROL  = 8'h23;
  localparam logic [7:0] IDX_WAKEUP_RELOAD_H = 8'h24;
  localparam logic [7:0] IDX_WAKEUP_RELOAD_L = 8'h25;
  localparam logic [7:0] IDX_WAKEUP_COUNT_H  = 8'h26;
  localparam logic [7:0] IDX_WAKEUP_COUNT_L  = 8'h27;
  localparam logic [7:0] IDX_T3_CONTROL      = 8'h30;
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'h31;
  localparam logic [7:0] IDX_IRQ_MASK        = 8'h32;
  // wake-up control fields
  localparam int WK_RUN_BIT     = 7;
  localparam int WK_QUAL_BIT    = 6;
  localparam int WK_TRIM_BIT    = 5;
  localparam int WK_DETECT_BIT  = 4;
  localparam int WK_RELOAD_BIT  = 3;
  localparam int WK_WAKE_BIT    = 2;
  localparam int WK_CLK_LSB     = 0;
  // third timer control fields (own layout)
  localparam int T3_START_BIT   = 0;
  localparam int T3_STOP_BIT    = 1;
  localparam int T3_RESTART_BIT = 2;
  localparam int T3_CLK_LSB     = 4;
  // interrupt status bits
  localparam int IRQ_T3_BIT     = 0;
  localparam int IRQ_WAKEUP_BIT = 1;
  localparam int IRQ_CARD_BIT   = 2;
  // reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  // tick rates: 13.56 MHz system clock and 211.875 kHz = system / 64
  localparam int SYS_TICK_PER_212K = 64;
  // wake-up prescaler divisors
  localparam int WK_DIV_8  = 8;
  localparam int WK_DIV_16 = 16;
  localparam int WK_DIV_32 = 32;
  typedef enum logic [1:0] {
    WK_IDLE,
    WK_DETECT
  } wk_state_type;
  typedef enum logic [1:0] {
    T3CLK_SYS  = 2'b00,
    T3CLK_212K = 2'b01,
    T3CLK_T0   = 2'b10,
    T3CLK_T1   = 2'b11
  } t3clk_type;
endpackage

// ---- src/down_counter16.sv ----
// 16-bit down counter with reload on start and optional auto reload
`timescale 1ns/1ps
`default_nettype none
module down_counter16
  import rtimer_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             start_i,
  input  wire logic             stop_i,
  input  wire logic             tick_i,
  input  wire logic             auto_reload_i,
  input  wire logic [WIDTH-1:0] reload_i,
  output logic      [WIDTH-1:0] count_o,
  output logic                  running_o,
  output logic                  underflow_o
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             run;
    logic             uf;
  } cnt_state_type;
  cnt_state_type cur_r;
  cnt_state_type cur_nxt;

  always_comb begin
    cur_nxt    = cur_r;
    cur_nxt.uf = 1'b0;
    if (start_i) begin
      // reload on a start or on an auto-reload underflow, so byte writes wait for the next start or reload
      cur_nxt.count = reload_i;
      cur_nxt.run   = 1'b1;
    end else if (stop_i) begin
      cur_nxt.run = 1'b0;
    end else if (cur_r.run && tick_i) begin
      if (cur_r.count == '0) begin
        cur_nxt.uf = 1'b1;
        if (auto_reload_i) begin
          cur_nxt.count = reload_i;
        end else begin
          cur_nxt.run = 1'b0;
        end
      end else begin
        cur_nxt.count = cur_r.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign count_o     = cur_r.count;
  assign running_o   = cur_r.run;
  assign underflow_o = cur_r.uf;
endmodule
`default_nettype wire

// ---- src/reload_wakeup_timer.sv ----
// timer unit: third timer reload/count and wake-up timer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module reload_wakeup_timer
  import rtimer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_B_I,
  // ***********************************
  // AXI4-Lite slave
  // ***********************************
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // ***********************************
  // surrounding logic
  // ***********************************
  input  wire logic              SYS_TICK_I,
  input  wire logic              OSC_TICK_I,
  input  wire logic              T0_UNDERFLOW_I,
  input  wire logic              T1_UNDERFLOW_I,
  input  wire logic              CARD_DETECT_DONE_I,
  input  wire logic              CARD_FOUND_I,
  output logic                   T3_UNDERFLOW_O,
  output logic                   WAKEUP_UNDERFLOW_O,
  output logic                   TRIM_START_O,
  output logic                   DETECT_START_O,
  output logic                   RF_FIELD_ON_O,
  output logic                   WAKE_O,
  output logic                   POWER_DOWN_O,
  output logic                   IRQ_O
);

  // ***********************************
  // state
  // ***********************************
  typedef struct packed {
    logic         awdone;
    logic [7:0]   awidx;
    logic         wdone;
    logic [31:0]  wdata;
    logic         wstb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [7:0]   t3_rel_h;
    logic [7:0]   t3_rel_l;
    logic [1:0]   t3_clk;
    logic         t3_restart;
    logic [7:0]   wk_ctrl;
    logic [7:0]   wk_rel_h;
    logic [7:0]   wk_rel_l;
    logic [5:0]   div212;
    logic [4:0]   osc_div;
    wk_state_type wk_st;
    logic [2:0]   irq_stat;
    logic [2:0]   irq_mask;
    logic         trim;
    logic         detect;
    logic         wake;
    logic         pdown;
  } top_state_type;
  top_state_type s_r;
  top_state_type s_nxt;

  logic [15:0] t3_count;
  logic        t3_run;
  logic        t3_uf;
  logic [15:0] wk_count;
  logic        wk_run;
  logic        wk_uf;
  logic        t3_tick;
  logic        wk_tick;
  logic        t3_start;
  logic        t3_stop;
  logic        wk_start;
  logic        wk_stop;
  logic        wr_go;
  logic        rd_go;

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = 8'(a >> 2);
  endfunction

  // ***********************************
  // tick generation
  // ***********************************
  always_comb begin
    unique case (t3clk_type'(s_r.t3_clk))
      T3CLK_SYS:  t3_tick = SYS_TICK_I;
      T3CLK_212K: t3_tick = SYS_TICK_I && (s_r.div212 == 6'(SYS_TICK_PER_212K - 1));
      T3CLK_T0:   t3_tick = T0_UNDERFLOW_I;
      T3CLK_T1:   t3_tick = T1_UNDERFLOW_I;
    endcase
  end

  always_comb begin
    unique case (s_r.wk_ctrl[WK_CLK_LSB +: 2])
      2'b00:   wk_tick = OSC_TICK_I;
      2'b01:   wk_tick = OSC_TICK_I && (s_r.osc_div[2:0] == 3'(WK_DIV_8 - 1));
      2'b10:   wk_tick = OSC_TICK_I && (s_r.osc_div[3:0] == 4'(WK_DIV_16 - 1));
      2'b11:   wk_tick = OSC_TICK_I && (s_r.osc_div == 5'(WK_DIV_32 - 1));
    endcase
  end

  // ***********************************
  // counters
  // ***********************************
  assign wr_go = s_r.awdone && s_r.wdone && !s_r.bvalid;
  assign rd_go = S_AXI_ARVALID && !s_r.rvalid;

  assign t3_start = (wr_go && s_r.wstb && s_r.awidx == IDX_T3_CONTROL && s_r.wdata[T3_START_BIT])
                    || (s_r.wk_st == WK_DETECT && wk_uf == 1'b0 && s_r.detect);
  assign t3_stop  = wr_go && s_r.wstb && s_r.awidx == IDX_T3_CONTROL && s_r.wdata[T3_STOP_BIT];

  // start or stop only when the qualifier bit is written one
  assign wk_start = wr_go && s_r.wstb && s_r.awidx == IDX_WAKEUP_CONTROL
                    && s_r.wdata[WK_QUAL_BIT] && s_r.wdata[WK_RUN_BIT];
  assign wk_stop  = wr_go && s_r.wstb && s_r.awidx == IDX_WAKEUP_CONTROL
                    && s_r.wdata[WK_QUAL_BIT] && !s_r.wdata[WK_RUN_BIT];

  down_counter16 #(
    .WIDTH(16)
  ) u_t3 (
    .clk_i        (CLK_I),
    .rst_b_i      (RST_B_I),
    .start_i      (t3_start),
    .stop_i       (t3_stop),
    .tick_i       (t3_tick),
    .auto_reload_i(s_r.t3_restart),
    .reload_i     ({s_r.t3_rel_h, s_r.t3_rel_l}),
    .count_o      (t3_count),
    .running_o    (t3_run),
    .underflow_o  (t3_uf)
  );

  // detection keeps the timer reloading so no gap appears between checks
  down_counter16 #(
    .WIDTH(16)
  ) u_wk (
    .clk_i        (CLK_I),
    .rst_b_i      (RST_B_I),
    .start_i      (wk_start),
    .stop_i       (wk_stop),
    .tick_i       (wk_tick),
    .auto_reload_i(s_r.wk_ctrl[WK_RELOAD_BIT] || s_r.wk_ctrl[WK_DETECT_BIT]),
    .reload_i     ({s_r.wk_rel_h, s_r.wk_rel_l}),
    .count_o      (wk_count),
    .running_o    (wk_run),
    .underflow_o  (wk_uf)
  );

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    logic [7:0] rd_idx;
    logic [7:0] rd_byte;
    logic       rd_ok;
    logic [2:0] irq_set;
    rd_idx  = word_index(S_AXI_ARADDR);
    rd_byte = RST_BYTE;
    rd_ok   = 1'b1;
    irq_set = 3'b000;
    s_nxt   = s_r;
    s_nxt.trim   = 1'b0;
    s_nxt.detect = 1'b0;
    s_nxt.wake   = 1'b0;

    if (SYS_TICK_I) begin
      s_nxt.div212 = s_r.div212 + 6'h01;
    end
    if (OSC_TICK_I) begin
      s_nxt.osc_div = s_r.osc_div + 5'h01;
    end
    if (wk_start) begin
      s_nxt.osc_div = 5'h00;
    end

    // write channel capture, either order
    if (S_AXI_AWVALID && !s_r.awdone) begin
      s_nxt.awdone = 1'b1;
      s_nxt.awidx  = word_index(S_AXI_AWADDR);
    end
    if (S_AXI_WVALID && !s_r.wdone) begin
      s_nxt.wdone = 1'b1;
      s_nxt.wdata = S_AXI_WDATA;
      s_nxt.wstb  = S_AXI_WSTRB[0];
    end
    if (wr_go) begin
      s_nxt.awdone = 1'b0;
      s_nxt.wdone  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = 2'b00;
      if (s_r.wstb) begin
        unique case (s_r.awidx)
          IDX_T3_RELOAD_HIGH:  s_nxt.t3_rel_h = s_r.wdata[7:0];
          IDX_T3_RELOAD_LOW:   s_nxt.t3_rel_l = s_r.wdata[7:0];
          IDX_WAKEUP_CONTROL:  s_nxt.wk_ctrl  = {1'b0, 1'b0, s_r.wdata[5:0]};
          IDX_WAKEUP_RELOAD_H: s_nxt.wk_rel_h = s_r.wdata[7:0];
          IDX_WAKEUP_RELOAD_L: s_nxt.wk_rel_l = s_r.wdata[7:0];
          IDX_T3_CONTROL: begin
            s_nxt.t3_restart = s_r.wdata[T3_RESTART_BIT];
            s_nxt.t3_clk     = s_r.wdata[T3_CLK_LSB +: 2];
          end
          IDX_IRQ_MASK:        s_nxt.irq_mask = s_r.wdata[2:0];
          IDX_IRQ_STATUS:      s_nxt.irq_stat = s_r.irq_stat & ~s_r.wdata[2:0];
          IDX_T3_COUNT_HIGH, IDX_T3_COUNT_LOW, IDX_WAKEUP_COUNT_H, IDX_WAKEUP_COUNT_L: ;
          default:             s_nxt.bresp = 2'b10;
        endcase
      end
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end

    // read channel
    unique case (rd_idx)
      IDX_T3_RELOAD_HIGH:  rd_byte = s_r.t3_rel_h;
      IDX_T3_RELOAD_LOW:   rd_byte = s_r.t3_rel_l;
      IDX_T3_COUNT_HIGH:   rd_byte = t3_count[15:8];
      IDX_T3_COUNT_LOW:    rd_byte = t3_count[7:0];
      IDX_WAKEUP_CONTROL:  rd_byte = {wk_run, 1'b0, s_r.wk_ctrl[5:0]};
      IDX_WAKEUP_RELOAD_H: rd_byte = s_r.wk_rel_h;
      IDX_WAKEUP_RELOAD_L: rd_byte = s_r.wk_rel_l;
      IDX_WAKEUP_COUNT_H:  rd_byte = wk_count[15:8];
      IDX_WAKEUP_COUNT_L:  rd_byte = wk_count[7:0];
      IDX_T3_CONTROL:      rd_byte = {2'b00, s_r.t3_clk, t3_run, s_r.t3_restart, 2'b00};
      IDX_IRQ_STATUS:      rd_byte = {5'h00, s_r.irq_stat};
      IDX_IRQ_MASK:        rd_byte = {5'h00, s_r.irq_mask};
      default:             rd_ok   = 1'b0;
    endcase
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = {24'h000000, rd_byte};
      s_nxt.rresp  = rd_ok ? 2'b00 : 2'b10;
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end

    // ***********************************
    // wake-up actions
    // ***********************************
    if (wk_uf) begin
      irq_set[IRQ_WAKEUP_BIT] = 1'b1;
      s_nxt.trim  = s_r.wk_ctrl[WK_TRIM_BIT];
      s_nxt.wake  = s_r.wk_ctrl[WK_WAKE_BIT];
      if (s_r.wk_ctrl[WK_WAKE_BIT]) begin
        s_nxt.pdown = 1'b0;
      end
      if (s_r.wk_ctrl[WK_DETECT_BIT]) begin
        s_nxt.detect = 1'b1;
        s_nxt.wk_st  = WK_DETECT;
      end
    end
    if (t3_uf) begin
      irq_set[IRQ_T3_BIT] = 1'b1;
    end
    unique case (s_r.wk_st)
      WK_IDLE: ;
      WK_DETECT: begin
        if (CARD_DETECT_DONE_I) begin
          s_nxt.wk_st = WK_IDLE;
          if (CARD_FOUND_I) begin
            irq_set[IRQ_CARD_BIT] = 1'b1;
          end else if (s_r.wk_ctrl[WK_WAKE_BIT]) begin
            s_nxt.pdown = 1'b1;
          end
        end
      end
      default: s_nxt.wk_st = WK_IDLE;
    endcase
    // hardware set wins over a same-cycle write-one clear
    s_nxt.irq_stat = s_nxt.irq_stat | irq_set;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_r       <= '0;
      s_r.wk_st <= WK_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign S_AXI_AWREADY      = !s_r.awdone;
  assign S_AXI_WREADY       = !s_r.wdone;
  assign S_AXI_BVALID       = s_r.bvalid;
  assign S_AXI_BRESP        = s_r.bresp;
  assign S_AXI_ARREADY      = !s_r.rvalid;
  assign S_AXI_RVALID       = s_r.rvalid;
  assign S_AXI_RDATA        = s_r.rdata;
  assign S_AXI_RRESP        = s_r.rresp;
  assign T3_UNDERFLOW_O     = t3_uf;
  assign WAKEUP_UNDERFLOW_O = wk_uf;
  assign TRIM_START_O       = s_r.trim;
  assign DETECT_START_O     = s_r.detect;
  // field stays on while timer three runs inside a presence check
  assign RF_FIELD_ON_O      = (s_r.wk_st == WK_DETECT) && t3_run;
  assign WAKE_O             = s_r.wake;
  assign POWER_DOWN_O       = s_r.pdown;
  assign IRQ_O              = |(s_r.irq_stat & s_r.irq_mask);
endmodule
`default_nettype wire

// ---- bench/reload_wakeup_timer_assertions.sv ----
// checker: bus answers and wake-up event ordering of the timer unit
`timescale 1ns/1ps
`default_nettype none
module reload_wakeup_timer_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        OSC_TICK_I,
  input wire logic        CARD_DETECT_DONE_I,
  input wire logic        WAKEUP_UNDERFLOW_O,
  input wire logic        TRIM_START_O,
  input wire logic        DETECT_START_O,
  input wire logic        WAKE_O,
  input wire logic        POWER_DOWN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  property p_trim; TRIM_START_O |-> $past(WAKEUP_UNDERFLOW_O); endproperty
  a_trim: assert property (p_trim) else $error("trim start without underflow");
  property p_detect; DETECT_START_O |-> $past(WAKEUP_UNDERFLOW_O); endproperty
  a_detect: assert property (p_detect) else $error("detect start without underflow");
  property p_wake; WAKE_O |-> $past(WAKEUP_UNDERFLOW_O); endproperty
  a_wake: assert property (p_wake) else $error("wake without underflow");
  property p_tick; WAKEUP_UNDERFLOW_O |-> $past(OSC_TICK_I) || $past(OSC_TICK_I, 2); endproperty
  a_tick: assert property (p_tick) else $error("underflow without oscillator tick");
  property p_pdown; $rose(POWER_DOWN_O) |-> $past(CARD_DETECT_DONE_I) || $past(CARD_DETECT_DONE_I, 2); endproperty
  a_pdown: assert property (p_pdown) else $error("power-down without detection end");
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_bans; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
  endproperty
  a_bans: assert property (p_bans) else $error("write response late");
  property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rbyte; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
  a_rbyte: assert property (p_rbyte) else $error("read data wider than a byte");
endmodule
bind reload_wakeup_timer reload_wakeup_timer_assertions #(.ADDR_W(ADDR_W)) chk_i (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .OSC_TICK_I(OSC_TICK_I), .CARD_DETECT_DONE_I(CARD_DETECT_DONE_I),
  .WAKEUP_UNDERFLOW_O(WAKEUP_UNDERFLOW_O), .TRIM_START_O(TRIM_START_O), .DETECT_START_O(DETECT_START_O),
  .WAKE_O(WAKE_O), .POWER_DOWN_O(POWER_DOWN_O));
`default_nettype wire

// ---- bench/reload_wakeup_timer_tb_top.sv ----
// testbench: register access, third timer reload and wake-up timer events
`timescale 1ns/1ps
`default_nettype none
module reload_wakeup_timer_tb_top;
  import rtimer_pkg::*;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, last_data;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_resp;
  logic        sys_tick, osc, t0_uf, t1_uf, cd_done, card, t3_uf, wk_uf, trim, det, rf_on, wake, pdown, irq;
  int          n_errors, total_checks, cyc, n_wuf, n_trim, n_wake, n_det, n_t3uf, base, k;
  reload_wakeup_timer reload_wakeup_timer_i (
    .CLK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SYS_TICK_I(sys_tick), .OSC_TICK_I(osc),
    .T0_UNDERFLOW_I(t0_uf), .T1_UNDERFLOW_I(t1_uf), .CARD_DETECT_DONE_I(cd_done), .CARD_FOUND_I(card),
    .T3_UNDERFLOW_O(t3_uf), .WAKEUP_UNDERFLOW_O(wk_uf), .TRIM_START_O(trim), .DETECT_START_O(det),
    .RF_FIELD_ON_O(rf_on), .WAKE_O(wake), .POWER_DOWN_O(pdown), .IRQ_O(irq));
  // ****************************************
  // clock, event counters and hang guard
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    n_wuf += wk_uf;
    n_trim += trim;
    n_wake += wake;
    n_det += det;
    n_t3uf += t3_uf;
    // the whole run needs about a thousand cycles; far beyond that means a hang
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ****************************************
  // bus and stimulus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bready and rready stay high, so a task never re-drives them at its last edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    awaddr <= {idx[5:0], 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_resp = bresp;
  endtask
  task automatic rd(input logic [7:0] idx);
    araddr <= {idx[5:0], 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    last_data = rdata;
    last_resp = rresp;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(last_data, {24'h0, exp});
  endtask
  // one oscillator tick every five cycles: follow-on pulses land two edges after the tick
  // and must be counted before the caller looks at the counters
  task automatic osc_ticks(input int n);
    repeat (n) begin
      @(posedge clk) osc <= 1'b1;
      @(posedge clk) osc <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic detect_end(input logic found);
    @(posedge clk) begin cd_done <= 1'b1; card <= found; end
    @(posedge clk) cd_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_third_timer;
    rd_chk(IDX_T3_RELOAD_HIGH, 8'h00);
    wr(IDX_T3_RELOAD_HIGH, 8'h12);
    wr(IDX_T3_RELOAD_LOW, 8'h34);
    rd_chk(IDX_T3_RELOAD_HIGH, 8'h12);
    rd_chk(IDX_T3_RELOAD_LOW, 8'h34);
    wr(IDX_T3_CONTROL, 8'h01);
    rd_chk(IDX_T3_COUNT_HIGH, 8'h12);
    wr(IDX_T3_RELOAD_HIGH, 8'h56);
    wr(IDX_T3_RELOAD_LOW, 8'h78);
    rd_chk(IDX_T3_COUNT_HIGH, 8'h12);
    rd_chk(IDX_T3_COUNT_LOW, 8'h34);
    wr(IDX_T3_CONTROL, 8'h01);
    @(posedge clk) sys_tick <= 1'b1;
    @(posedge clk) sys_tick <= 1'b0;
    wr(IDX_T3_COUNT_HIGH, 8'hff);
    rd_chk(IDX_T3_COUNT_HIGH, 8'h56);
    rd_chk(IDX_T3_COUNT_LOW, 8'h77);
    // clocked from timer zero underflows: system ticks must not count
    wr(IDX_T3_RELOAD_HIGH, 8'h00);
    wr(IDX_T3_RELOAD_LOW, 8'h01);
    wr(IDX_T3_CONTROL, 8'h21);
    @(posedge clk) sys_tick <= 1'b1;
    @(posedge clk) begin
      sys_tick <= 1'b0;
      t0_uf <= 1'b1;
    end
    @(posedge clk) t0_uf <= 1'b0;
    rd_chk(IDX_T3_COUNT_LOW, 8'h00);
    base = n_t3uf;
    @(posedge clk) t0_uf <= 1'b1;
    @(posedge clk) t0_uf <= 1'b0;
    rd_chk(IDX_T3_CONTROL, 8'h20);
    chk(n_t3uf - base, 1);
    rd(8'h3f);
    chk({30'h0, last_resp}, 32'h2);
    chk(last_data, 32'h0);
    $display("done third timer");
  endtask
  task automatic t_divider;
    wr(IDX_WAKEUP_RELOAD_H, 8'h00);
    wr(IDX_WAKEUP_RELOAD_L, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_WAKEUP_CONTROL, 8'hc0 | 8'(c));
      rd_chk(IDX_WAKEUP_COUNT_L, 8'h01);
      base = n_wuf;
      k = 0;
      while (n_wuf == base && k < 100) begin
        osc_ticks(1);
        k++;
      end
      chk(k, (c == 0) ? 2 : 2 * (4 << c));
      rd_chk(IDX_WAKEUP_CONTROL, 8'(c));
      rd(IDX_IRQ_STATUS);
      chk(last_data & 32'h2, 32'h2);
      wr(IDX_IRQ_STATUS, 8'h02);
    end
    $display("done divider");
  endtask
  task automatic t_run_reload;
    wr(IDX_WAKEUP_CONTROL, 8'hc8);
    base = n_wuf;
    osc_ticks(4);
    chk(n_wuf - base, 2);
    rd_chk(IDX_WAKEUP_CONTROL, 8'h88);
    wr(IDX_WAKEUP_CONTROL, 8'h08);
    rd_chk(IDX_WAKEUP_CONTROL, 8'h88);
    wr(IDX_WAKEUP_CONTROL, 8'h48);
    rd_chk(IDX_WAKEUP_CONTROL, 8'h08);
    base = n_wuf;
    osc_ticks(4);
    chk(n_wuf - base, 0);
    wr(IDX_WAKEUP_RELOAD_L, 8'h03);
    rd_chk(IDX_WAKEUP_COUNT_L, 8'h01);
    wr(IDX_WAKEUP_RELOAD_L, 8'h01);
    $display("done run and reload");
  endtask
  task automatic t_events;
    wr(IDX_IRQ_STATUS, 8'h07);
    wr(IDX_IRQ_MASK, 8'h02);
    chk(irq, 1'b0);
    base = n_trim + n_wake;
    wr(IDX_WAKEUP_CONTROL, 8'he4);
    osc_ticks(2);
    chk(n_trim + n_wake - base, 2);
    chk(irq, 1'b1);
    wr(IDX_IRQ_STATUS, 8'h02);
    chk(irq, 1'b0);
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_WAKEUP_CONTROL, 8'hc0);
    osc_ticks(2);
    chk(irq, 1'b0);
    chk(n_wake - base, 1);
    wr(IDX_IRQ_STATUS, 8'h02);
    $display("done events");
  endtask
  task automatic t_detect;
    wr(IDX_IRQ_MASK, 8'h04);
    base = n_det;
    wr(IDX_WAKEUP_CONTROL, 8'hd4);
    osc_ticks(2);
    chk(n_det - base, 1);
    chk(rf_on, 1'b1);
    detect_end(1'b0);
    chk(pdown, 1'b1);
    chk(rf_on, 1'b0);
    osc_ticks(2);
    chk(n_det - base, 2);
    chk(pdown, 1'b0);
    detect_end(1'b1);
    chk(irq, 1'b1);
    wr(IDX_WAKEUP_CONTROL, 8'h40);
    wr(IDX_IRQ_STATUS, 8'h07);
    $display("done detect");
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_b, awvalid, wvalid, arvalid, sys_tick, osc, t0_uf, t1_uf, cd_done, card} = '0;
    {awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h31;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_third_timer();
    t_divider();
    t_run_reload();
    t_events();
    t_detect();
    report_and_stop();
  end
endmodule
`default_nettype wire
